// ### dv/fsk_data_port_mode_control_tb.sv
`timescale 1ns/1ps
`include "fskd_consts.svh"

module fsk_data_port_mode_control_tb;
    logic       sys_clk, rst, reg_we, reg_re, pll_lock_raw, demod_data;
    logic [6:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, v;
    logic       mod_data, xco_run, rx_enable, tx_enable, lna_b, lock_pin, lock_oe_n, bclk;
    logic [2:0] pa;
    logic       sdat_in, sdat_out, sdat_oe_n, sync_mode, drive_on, next_bit, float_t;
    logic       host_en, host_bit, rx_sample;
    int         err_count, tests_run, seed, r, n0, n1;
    logic [6:0] addrs [4] = '{`FSKD_A_FRONT, `FSKD_A_FILT, `FSKD_A_CLKSEL, `FSKD_A_CLKDIV};

    // ----------------------------------------
    // Clock, pin resolution, instances
    // ----------------------------------------
    always #2.5 sys_clk = ~sys_clk;
    // Released pin has no pull, so it wanders
    always @(posedge sys_clk) float_t <= ~float_t;
    assign sdat_in = !sdat_oe_n ? sdat_out : (host_en ? host_bit : float_t);

    fskd_data_port DUT (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_we(reg_we), .reg_re(reg_re),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pll_lock_raw(pll_lock_raw), .demod_data(demod_data),
        .mod_data(mod_data), .xco_run(xco_run), .rx_enable(rx_enable), .tx_enable(tx_enable),
        .tx_power_level(pa), .low_noise_amp_bypass(lna_b), .pll_locked_pin(lock_pin),
        .pll_locked_oe_n(lock_oe_n), .bit_clock_pin(bclk), .serial_bit_in(sdat_in),
        .serial_bit_out(sdat_out), .serial_bit_oe_n(sdat_oe_n));

    fskd_host_mdl HOST (.bit_clock_pin(bclk), .serial_bit_out(sdat_out), .sync_mode(sync_mode),
        .drive_on(drive_on), .next_bit(next_bit), .host_en(host_en), .host_bit(host_bit), .rx_sample(rx_sample));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [7:0] fe(input logic [1:0] m, input logic s, input logic [2:0] p, input logic l);
        return {l, p, s, m, 1'b0};
    endfunction

    function automatic int half_exp(input int k, input int s);
        return k * (1 << (6 - s));
    endfunction

    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_we = 1'b1;
        tick(1);
        reg_we = 1'b0;
        tick(1);
    endtask

    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        reg_addr = a;
        reg_re = 1'b1;
        tick(1);
        reg_re = 1'b0;
        tick(1);
        d = reg_rdata;
    endtask

    // Bounded wait for a clock pin level
    task automatic wait_lvl(input logic lv, output int n);
        n = 0;
        while (bclk !== lv && n < 3000) begin
            tick(1);
            n++;
        end
    endtask

    task automatic cfg(input logic [5:0] k, input logic [2:0] s, input logic [2:0] rs);
        wr(`FSKD_A_CLKSEL, {4'h0, rs, s[2]});
        wr(`FSKD_A_CLKDIV, {s[1:0], k});
    endtask

    // Rate clock period and data taken on each rise
    task automatic sync_tx(input logic [5:0] k, input logic [2:0] s);
        cfg(k, s, 3'h0);
        tick(4);
        // Skip any phase begun under the old setting
        wait_lvl(1'b0, n0);
        wait_lvl(1'b1, n0);
        wait_lvl(1'b0, n0);
        wait_lvl(1'b1, n1);
        chk(16'(n0 + n1), 16'(2 * half_exp(k, s)), "rate period");
        repeat (6) begin
            r = $random(seed);
            next_bit = r[0];
            wait_lvl(1'b0, n0);
            wait_lvl(1'b1, n0);
            chk({sdat_oe_n, mod_data}, {1'b1, r[0]}, "tx bit");
        end
    endtask

    task final_report;
        $display("counts: tests_run=%0d err_count=%0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        {sys_clk, reg_we, reg_re, pll_lock_raw, demod_data, sync_mode, drive_on, next_bit, float_t} = '0;
        reg_addr = 7'h00;
        reg_wdata = 8'h00;
        err_count = 0;
        tests_run = 0;
        seed = 22294;
        rst = 1'b1;
        tick(8);
        rst = 1'b0;
        tick(1);
        foreach (addrs[i]) begin
            rd(addrs[i], v);
            chk(v, 16'h0000, "reset reg");
        end
        chk({xco_run, rx_enable, tx_enable, lock_oe_n, sdat_oe_n}, 16'h0003, "reset pins");
        foreach (addrs[i]) begin
            r = $random(seed);
            wr(addrs[i], r[7:0]);
            rd(addrs[i], v);
            chk(v, 16'(r[7:0]), "readback");
        end
        wr(7'h05, 8'hFF);
        rd(7'h05, v);
        chk(v, 16'h0000, "unmapped");
        $display("test registers done");
        for (int m = 0; m < 4; m++) begin
            r = $random(seed);
            wr(`FSKD_A_FRONT, fe(m[1:0], 1'b0, r[2:0], r[3]));
            tick(3);
            chk({xco_run, rx_enable, tx_enable}, {m != 0, m == 2, m == 3}, "state decode");
            chk({lna_b, pa}, 16'(r[3:0]), "pa level");
        end
        $display("test states done");
        wr(`FSKD_A_FILT, 8'h04);
        repeat (12) begin
            r = $random(seed);
            pll_lock_raw = r[0];
            tick(8);
            chk({lock_oe_n, lock_pin}, {1'b0, r[0]}, "lock on");
        end
        pll_lock_raw = 1'b1;
        tick(8);
        wr(`FSKD_A_FILT, 8'h00);
        tick(3);
        chk(lock_oe_n, 16'h0001, "lock off");
        chk({lock_oe_n, lock_pin}, 16'h0002, "lock pin off");
        $display("test lock done");
        wr(`FSKD_A_FRONT, fe(2'h2, 1'b0, 3'h0, 1'b0));
        repeat (12) begin
            r = $random(seed);
            demod_data = r[0];
            tick(8);
            chk({sdat_oe_n, bclk, sdat_out}, {2'h0, r[0]}, "async rx");
        end
        $display("test async rx done");
        wr(`FSKD_A_FRONT, fe(2'h3, 1'b0, 3'h0, 1'b0));
        tick(4);
        drive_on = 1'b1;
        repeat (12) begin
            r = $random(seed);
            next_bit = r[0];
            tick(8);
            chk({sdat_oe_n, bclk, mod_data}, {2'h2, r[0]}, "async tx");
        end
        $display("test async tx done");
        sync_mode = 1'b1;
        wr(`FSKD_A_FRONT, fe(2'h3, 1'b1, 3'h0, 1'b0));
        sync_tx(6'h08, 3'h6);
        sync_tx(6'h01, 3'h0);
        repeat (3) begin
            r = $random(seed);
            sync_tx(6'(r[1:0] % 3 + 1), 3'(r[3:2]));
        end
        // Zero divider must hold the clock low
        cfg(6'h00, 3'h6, 3'h0);
        tick(4);
        wait_lvl(1'b1, n0);
        chk(16'(n0), 16'hBB8, "k zero");
        $display("test sync tx done");
        drive_on = 1'b0;
        wr(`FSKD_A_FRONT, fe(2'h2, 1'b1, 3'h0, 1'b0));
        cfg(6'h02, 3'h0, 3'h4);
        repeat (8) begin
            r = $random(seed);
            demod_data = r[0];
            tick(6);
            wait_lvl(1'b1, n0);
            wait_lvl(1'b0, n0);
            chk({sdat_oe_n, rx_sample}, {1'b0, r[0]}, "sync rx");
        end
        $display("test sync rx done");
        final_report;
    end

    // Whole run needs well under this span
    initial begin
        #400000;
        err_count++;
        $display("unexpected at %0t: watchdog expired", $time);
        final_report;
    end
endmodule // fsk_data_port_mode_control_tb

// ### dv/fskd_host_mdl.sv
`timescale 1ns/1ps

module fskd_host_mdl (
    // Device pins seen by the host
    input  wire logic bit_clock_pin,
    input  wire logic serial_bit_out,
    // Bench control
    input  wire logic sync_mode,
    input  wire logic drive_on,
    input  wire logic next_bit,
    // Host pin drive and received bit
    output logic      host_en,
    output logic      host_bit,
    output logic      rx_sample
);
    // ----------------------------------------
    // Host data pin
    // ----------------------------------------
    // Released until sending starts, modulator sees no early drive
    assign host_en = drive_on;

    logic sync_bit;

    initial begin
        sync_bit  = 1'b0;
        rx_sample = 1'b0;
    end

    // Change only on falling clock, device samples on rise
    always @(negedge bit_clock_pin) begin
        if (sync_mode) begin
            sync_bit <= next_bit;
        end
    end

    // No clock when transparent, host paces itself
    assign host_bit = sync_mode ? sync_bit : next_bit;

    // Receive data taken on falling clock
    always @(negedge bit_clock_pin) begin
        rx_sample <= serial_bit_out;
    end
endmodule // fskd_host_mdl

// ### rtl/fskd_consts.svh
`ifndef FSKD_CONSTS_SVH
`define FSKD_CONSTS_SVH

// ----------------------------------------
// Register addresses (7-bit)
// ----------------------------------------
`define FSKD_A_FRONT     7'h00
`define FSKD_A_FILT      7'h01
`define FSKD_A_CLKSEL    7'h06
`define FSKD_A_CLKDIV    7'h07
`define FSKD_CFG_RST     8'h00
`define FSKD_RD_ZERO     8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FSKD_FE_LNA      7
`define FSKD_FE_PA_HI    6
`define FSKD_FE_PA_LO    4
`define FSKD_FE_SYNC     3
`define FSKD_FE_MODE_HI  2
`define FSKD_FE_MODE_LO  1
`define FSKD_FM_LOCK     2
`define FSKD_CS_RATE_HI  0
`define FSKD_CS_BSYN_HI  3
`define FSKD_CS_BSYN_LO  1
`define FSKD_CD_RATE_HI  7
`define FSKD_CD_RATE_LO  6
`define FSKD_CD_K_HI     5
`define FSKD_CD_K_LO     0

// ----------------------------------------
// Divider limits
// ----------------------------------------
`define FSKD_RATE_MAX    3'h6
`define FSKD_K_ZERO      6'h00
`define FSKD_CNT_ZERO    12'h000
`define FSKD_CNT_ONE     12'h001
`define FSKD_SH_TOP      3'h6

`endif

// ### rtl/fskd_data_port.sv
`timescale 1ns/1ps
`include "fskd_consts.svh"

// Summary of operation
// RULE1 - Lock pin driven only with detector enabled
// RULE2 - Lock pin high while PLL locked
// RULE3 - State 00 down, 01 standby, 10 receive
// RULE4 - State 11 transmit; PA level separate
// RULE5 - Async receive passes demodulated data straight
// RULE6 - Async transmit: clock off, data transparent
// RULE7 - Sync receive outputs recovered bit clock
// RULE8 - Sync transmit outputs programmed rate clock
// RULE9 - Sync transmit samples data on rising clock
// RULE10 - Host changes transmit data on falling edge
// RULE11 - Rate clock = ref / (K * 2^(7-S))
// RULE12 - Divider K six bits, 1 to 63
// RULE13 - Rate select 0 to 6, split field
// RULE14 - Host sets rate clock to bit rate
// RULE15 - Device is data clock master when synchronous
// RULE16 - Receive data changes on rise, host samples fall
// RULE17 - Host keeps data pin floating until sending
// RULE18 - Transmit data goes straight to modulator

module fskd_data_port
    import fskd_pkg::*;
(
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst,
    // Register port
    input  wire logic [6:0] reg_addr,
    input  wire logic       reg_we,
    input  wire logic       reg_re,
    input  wire logic [7:0] reg_wdata,
    output logic [7:0]      reg_rdata,
    // Analog side
    input  wire logic       pll_lock_raw,
    input  wire logic       demod_data,
    output logic            mod_data,
    output logic            xco_run,
    output logic            rx_enable,
    output logic            tx_enable,
    output logic [2:0]      tx_power_level,
    output logic            low_noise_amp_bypass,
    // Lock pin
    output logic            pll_locked_pin,
    output logic            pll_locked_oe_n,
    // Data clock pin
    output logic            bit_clock_pin,
    // Data pin, two-way
    input  wire logic       serial_bit_in,
    output logic            serial_bit_out,
    output logic            serial_bit_oe_n
);

    fskd_st_t    st_r;
    fskd_st_t    st_nxt;
    fskd_op_t    op_c;
    logic        sync_en_c;
    logic        lock_en_c;
    logic        tx_sync_c;
    logic        rx_sync_c;
    logic [2:0]  rate_sel_c;
    logic [2:0]  bsyn_sel_c;
    logic [5:0]  ref_div_c;
    logic        lock_s;
    logic        demod_s;
    logic        sdat_s;
    logic        tx_clk;
    logic        tx_rise;
    logic        rx_clk;
    logic        rx_rise;
    logic        demod_edge_c;

    // ----------------------------------------
    // Pin input synchronisers
    // ----------------------------------------
    fskd_sync3 u_sync_lock (
        .sys_clk (sys_clk),
        .rst     (rst),
        .din     (pll_lock_raw),
        .dout    (lock_s)
    );

    fskd_sync3 u_sync_demod (
        .sys_clk (sys_clk),
        .rst     (rst),
        .din     (demod_data),
        .dout    (demod_s)
    );

    fskd_sync3 u_sync_sdat (
        .sys_clk (sys_clk),
        .rst     (rst),
        .din     (serial_bit_in),
        .dout    (sdat_s)
    );

    // ----------------------------------------
    // Field decode
    // ----------------------------------------
    always_comb begin
        op_c       = fskd_op_t'(st_r.fe_cfg[`FSKD_FE_MODE_HI:`FSKD_FE_MODE_LO]); // RULE3
        sync_en_c  = st_r.fe_cfg[`FSKD_FE_SYNC];
        lock_en_c  = st_r.fm_cfg[`FSKD_FM_LOCK];
        rate_sel_c = {st_r.cs_cfg[`FSKD_CS_RATE_HI],
                      st_r.cd_cfg[`FSKD_CD_RATE_HI:`FSKD_CD_RATE_LO]}; // RULE13
        bsyn_sel_c = st_r.cs_cfg[`FSKD_CS_BSYN_HI:`FSKD_CS_BSYN_LO];
        ref_div_c  = st_r.cd_cfg[`FSKD_CD_K_HI:`FSKD_CD_K_LO]; // RULE12
        tx_sync_c  = (op_c == FSKD_OP_TX) && sync_en_c;
        rx_sync_c  = (op_c == FSKD_OP_RX) && sync_en_c;
        // Re-phase the recovered clock on each data transition
        demod_edge_c = demod_s != st_r.demod_prev;
    end

    // ----------------------------------------
    // Bit clock generators
    // ----------------------------------------
    // Transmit rate clock from rate select
    fskd_rate_div u_tx_div (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .ref_div  (ref_div_c),
        .rate_sel (rate_sel_c),
        .run      (tx_sync_c),
        .restart  (1'b0),
        .clk_o    (tx_clk),
        .rise_o   (tx_rise)
    );

    // Simple synchroniser: rising edge lands mid-bit after a transition
    fskd_rate_div u_rx_div (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .ref_div  (ref_div_c),
        .rate_sel (bsyn_sel_c),
        .run      (rx_sync_c),
        .restart  (demod_edge_c),
        .clk_o    (rx_clk),
        .rise_o   (rx_rise)
    );

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        st_nxt            = st_r;
        st_nxt.demod_prev = demod_s;

        // Register writes; power down keeps all contents
        if (reg_we) begin
            case (reg_addr)
                `FSKD_A_FRONT: st_nxt.fe_cfg = reg_wdata;
                `FSKD_A_FILT:   st_nxt.fm_cfg = reg_wdata;
                `FSKD_A_CLKSEL: st_nxt.cs_cfg = reg_wdata;
                `FSKD_A_CLKDIV: st_nxt.cd_cfg = reg_wdata;
                default:        st_nxt.fe_cfg = st_r.fe_cfg;
            endcase
        end
        if (reg_re) begin
            case (reg_addr)
                `FSKD_A_FRONT: st_nxt.rdata = st_r.fe_cfg;
                `FSKD_A_FILT:   st_nxt.rdata = st_r.fm_cfg;
                `FSKD_A_CLKSEL: st_nxt.rdata = st_r.cs_cfg;
                `FSKD_A_CLKDIV: st_nxt.rdata = st_r.cd_cfg;
                default:        st_nxt.rdata = `FSKD_RD_ZERO;
            endcase
        end

        // Lock indication
        st_nxt.lock_oe_n = !lock_en_c; // RULE1
        st_nxt.lock_pin  = lock_en_c && lock_s; // RULE1 RULE2

        // Operating state
        st_nxt.pa_level = st_r.fe_cfg[`FSKD_FE_PA_HI:`FSKD_FE_PA_LO]; // RULE4
        st_nxt.lna_byp  = st_r.fe_cfg[`FSKD_FE_LNA];
        case (op_c)
            FSKD_OP_DOWN: begin
                st_nxt.xco_run = 1'b0; // RULE3
                st_nxt.rx_on   = 1'b0;
                st_nxt.tx_on   = 1'b0;
            end
            FSKD_OP_STBY: begin
                st_nxt.xco_run = 1'b1; // RULE3
                st_nxt.rx_on   = 1'b0;
                st_nxt.tx_on   = 1'b0;
            end
            FSKD_OP_RX: begin
                st_nxt.xco_run = 1'b1; // RULE3
                st_nxt.rx_on   = 1'b1;
                st_nxt.tx_on   = 1'b0;
            end
            FSKD_OP_TX: begin
                st_nxt.xco_run = 1'b1; // RULE4
                st_nxt.rx_on   = 1'b0;
                st_nxt.tx_on   = 1'b1;
            end
            default: begin
                st_nxt.xco_run = 1'b0;
                st_nxt.rx_on   = 1'b0;
                st_nxt.tx_on   = 1'b0;
            end
        endcase

        // Data interface; device is clock master when synchronous
        st_nxt.bclk      = 1'b0; // RULE6
        st_nxt.sdat_oe_n = 1'b1; // RULE17
        if (op_c == FSKD_OP_RX) begin
            st_nxt.sdat_oe_n = 1'b0;
            if (sync_en_c) begin
                st_nxt.bclk = rx_clk; // RULE7 RULE15
                if (rx_rise) begin
                    st_nxt.sdat_out = demod_s; // RULE16
                end
            end else begin
                st_nxt.sdat_out = demod_s; // RULE5
            end
        end else if (op_c == FSKD_OP_TX) begin
            if (sync_en_c) begin
                st_nxt.bclk = tx_clk; // RULE8 RULE15
                // Host moves data on the falling edge, so rise is safe
                if (tx_rise) begin
                    st_nxt.mod_data = sdat_s; // RULE9 RULE10
                end
            end else begin
                // No encoding; the host owns the data rate here
                st_nxt.mod_data = sdat_s; // RULE6 RULE18
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_r           <= '0;
            // Pins released in reset; lock pin only with detector on
            st_r.lock_oe_n <= 1'b1; // RULE1
            st_r.sdat_oe_n <= 1'b1; // RULE17
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign reg_rdata            = st_r.rdata;
    assign mod_data             = st_r.mod_data;
    assign xco_run              = st_r.xco_run;
    assign rx_enable            = st_r.rx_on;
    assign tx_enable            = st_r.tx_on;
    assign tx_power_level       = st_r.pa_level;
    assign low_noise_amp_bypass = st_r.lna_byp;
    assign pll_locked_pin       = st_r.lock_pin;
    assign pll_locked_oe_n      = st_r.lock_oe_n;
    assign bit_clock_pin        = st_r.bclk;
    assign serial_bit_out       = st_r.sdat_out;
    assign serial_bit_oe_n      = st_r.sdat_oe_n;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_lock_off;
        @(posedge sys_clk) disable iff (rst)
        !lock_en_c |=> !pll_locked_pin && pll_locked_oe_n;
    endproperty
    a_lock_off: assert property (p_lock_off) else $error("lock pin active while disabled"); // RULE1

    property p_lock_on;
        @(posedge sys_clk) disable iff (rst)
        lock_en_c && lock_s |=> pll_locked_pin && !pll_locked_oe_n;
    endproperty
    a_lock_on: assert property (p_lock_on) else $error("lock pin missing while locked"); // RULE2

    property p_state_low;
        @(posedge sys_clk) disable iff (rst)
        (op_c == FSKD_OP_DOWN) || (op_c == FSKD_OP_STBY) |=>
            !rx_enable && !tx_enable && (xco_run == ($past(op_c) == FSKD_OP_STBY));
    endproperty
    a_state_low: assert property (p_state_low) else $error("down or standby decode wrong"); // RULE3

    property p_state_tx;
        @(posedge sys_clk) disable iff (rst)
        (op_c == FSKD_OP_TX) |=> tx_enable && !rx_enable && xco_run;
    endproperty
    a_state_tx: assert property (p_state_tx) else $error("transmit decode wrong"); // RULE4

    property p_rx_async;
        @(posedge sys_clk) disable iff (rst)
        (op_c == FSKD_OP_RX) && !sync_en_c |=>
            serial_bit_out == $past(demod_s) && !serial_bit_oe_n && !bit_clock_pin;
    endproperty
    a_rx_async: assert property (p_rx_async) else $error("receive data not transparent"); // RULE5

    property p_tx_async;
        @(posedge sys_clk) disable iff (rst)
        (op_c == FSKD_OP_TX) && !sync_en_c |=>
            !bit_clock_pin && serial_bit_oe_n && mod_data == $past(sdat_s);
    endproperty
    a_tx_async: assert property (p_tx_async) else $error("async transmit path wrong"); // RULE6

    sequence s_tx_rise;
        $past(tx_sync_c) ##0 $rose(bit_clock_pin);
    endsequence

    property p_tx_sample;
        @(posedge sys_clk) disable iff (rst)
        s_tx_rise |-> mod_data == $past(sdat_s);
    endproperty
    a_tx_sample: assert property (p_tx_sample) else $error("transmit bit not sampled on rise"); // RULE9

    property p_tx_hold;
        @(posedge sys_clk) disable iff (rst)
        tx_sync_c && $past(tx_sync_c) && !$rose(bit_clock_pin) |-> $stable(mod_data);
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("transmit bit moved off the rising edge"); // RULE9

    property p_rx_update;
        @(posedge sys_clk) disable iff (rst)
        $past(rx_sync_c) && rx_sync_c && $changed(serial_bit_out) |-> $rose(bit_clock_pin);
    endproperty
    a_rx_update: assert property (p_rx_update) else $error("receive bit changed off the rising edge"); // RULE16

endmodule // fskd_data_port

// ### rtl/fskd_pkg.sv
package fskd_pkg;

    typedef enum logic [1:0] {
        FSKD_OP_DOWN,
        FSKD_OP_STBY,
        FSKD_OP_RX,
        FSKD_OP_TX
    } fskd_op_t;

    typedef struct packed {
        logic [2:0] sh;
        logic       val;
    } fskd_sync_st_t;

    typedef struct packed {
        logic [11:0] cnt;
        logic        clk;
        logic        rise;
    } fskd_div_st_t;

    typedef struct packed {
        logic [7:0] fe_cfg;
        logic [7:0] fm_cfg;
        logic [7:0] cs_cfg;
        logic [7:0] cd_cfg;
        logic [7:0] rdata;
        logic       lock_pin;
        logic       lock_oe_n;
        logic       bclk;
        logic       sdat_out;
        logic       sdat_oe_n;
        logic       mod_data;
        logic       xco_run;
        logic       rx_on;
        logic       tx_on;
        logic [2:0] pa_level;
        logic       lna_byp;
        logic       demod_prev;
    } fskd_st_t;

endpackage

// ### rtl/fskd_rate_div.sv
`timescale 1ns/1ps
`include "fskd_consts.svh"

module fskd_rate_div
    import fskd_pkg::*;
(
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst,
    // Divider setting
    input  wire logic [5:0] ref_div,
    input  wire logic [2:0] rate_sel,
    input  wire logic       run,
    input  wire logic       restart,
    // Divided clock
    output logic            clk_o,
    output logic            rise_o
);

    fskd_div_st_t st_r;
    fskd_div_st_t st_nxt;
    logic [2:0]   sel_c;
    logic [11:0]  half_c;
    logic         go_c;

    // ----------------------------------------
    // Half period = K * 2^(6-S); codes above six act as six
    // ----------------------------------------
    always_comb begin
        sel_c  = (rate_sel > `FSKD_RATE_MAX) ? `FSKD_RATE_MAX : rate_sel; // RULE13
        half_c = {6'h00, ref_div} << (`FSKD_RATE_MAX - sel_c); // RULE11
        // Zero divider is illegal; hold the clock rather than spin
        go_c   = run && (ref_div != `FSKD_K_ZERO); // RULE12
    end

    always_comb begin
        st_nxt      = st_r;
        st_nxt.rise = 1'b0;
        if (!go_c || restart) begin
            st_nxt.cnt = `FSKD_CNT_ZERO;
            st_nxt.clk = 1'b0;
        end else if (st_r.cnt + `FSKD_CNT_ONE >= half_c) begin // RULE11
            st_nxt.cnt  = `FSKD_CNT_ZERO;
            st_nxt.clk  = !st_r.clk;
            st_nxt.rise = !st_r.clk;
        end else begin
            st_nxt.cnt = st_r.cnt + `FSKD_CNT_ONE;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign clk_o  = st_r.clk;
    assign rise_o = st_r.rise;

    property p_half_bound;
        @(posedge sys_clk) disable iff (rst)
        // Setting may shrink mid-count; the wrap must still land below it
        go_c && !restart && (half_c != `FSKD_CNT_ZERO) |=> st_r.cnt < $past(half_c);
    endproperty
    a_half_bound: assert property (p_half_bound) else $error("divider count past half period"); // RULE11

endmodule // fskd_rate_div

// ### rtl/fskd_sync3.sv
`timescale 1ns/1ps
`include "fskd_consts.svh"

module fskd_sync3
    import fskd_pkg::*;
(
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst,
    // Async level in, settled level out
    input  wire logic din,
    output logic      dout
);

    fskd_sync_st_t st_r;
    fskd_sync_st_t st_nxt;

    // ----------------------------------------
    // Three stages; a change counts once stages two and three agree
    // ----------------------------------------
    always_comb begin
        st_nxt    = st_r;
        st_nxt.sh = {st_r.sh[1:0], din};
        if (st_r.sh[1] == st_r.sh[2]) begin
            st_nxt.val = st_r.sh[2];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign dout = st_r.val;

endmodule // fskd_sync3
